/* rtl/tbc_pkg.sv */
// Package with register map, field layout and encodings of the timer B configuration block.
package tbc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_GLOBAL_CFG = 12'h000;
    localparam logic [11:0] OFS_HALF_A_MODE = 12'h004;
    localparam logic [11:0] OFS_HALF_B_MODE = 12'h008;
    localparam logic [11:0] OFS_CONTROL = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_LSB = 0;
    localparam int MODE_FIELD_LSB = 0;
    localparam int MODE_CAPSTYLE_BIT = 2;
    localparam int MODE_ALT_BIT = 3;
    localparam int CTL_EDGE_LSB = 10;
    localparam int CTL_TRIG_BIT = 13;
    localparam int CTL_INV_BIT = 14;

    // Writable bits of the control register: 14, 13, 11:10.
    localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_6C00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_CFG = 3'h0;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TBC_MODE_RSVD = 2'h0,
        TBC_MODE_ONESHOT = 2'h1,
        TBC_MODE_PERIODIC = 2'h2,
        TBC_MODE_CAPTURE = 2'h3
    } tbc_mode_e;

    typedef enum logic [1:0] {
        TBC_EDGE_RISE = 2'h0,
        TBC_EDGE_FALL = 2'h1,
        TBC_EDGE_RSVD = 2'h2,
        TBC_EDGE_BOTH = 2'h3
    } tbc_edge_e;

    // Global configuration value 4 and above selects split operation.
    localparam logic [2:0] CFG_SPLIT_MIN = 3'h4;

    // Per-half mode register contents.
    typedef struct packed {
        logic alt_select;
        logic capture_style;
        logic [1:0] mode;
    } tbc_mode_s;

    // Effective configuration handed to the timer B datapath.
    typedef struct packed {
        logic split;
        logic [1:0] mode;
        logic pwm_en;
        logic edge_time;
        logic [1:0] edge_sel;
        logic rise_en;
        logic fall_en;
    } tbc_eff_s;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

/* rtl/tbc_mode_reg.sv */
// Four-bit per-half mode register with write strobe.
`timescale 1ns/1ps
`default_nettype none

module tbc_mode_reg (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_data_i,
    // Stored value
    output tbc_pkg::tbc_mode_s value_o
);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            value_o <= tbc_pkg::RST_MODE;
        end else if (wr_en_i) begin
            value_o <= wr_data_i;
        end
    end

endmodule

`default_nettype wire

/* rtl/tbc_edge_sync.sv */
// Three-stage synchroniser with agreement filter and edge detection.
`timescale 1ns/1ps
`default_nettype none

module tbc_edge_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Asynchronous pin
    input wire logic pin_i,
    // Filtered level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic s1;
    logic s2;
    logic s3;
    logic agree;

    // Only s2 and s3 are compared; s1 may still be metastable.
    assign agree = (s2 == s3);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                level_o <= s3;
            end
            rise_o <= agree && s3 && !level_o;
            fall_o <= agree && !s3 && level_o;
        end
    end

endmodule

`default_nettype wire

/* rtl/tbc_top.sv */
// Timer B mode and control configuration block with AHB-Lite register slave.
//
// Notes on behaviour
// R1: Mode field 1 one-shot, 2 periodic, 3 capture, 0 reserved.
// R2: Mode field is read in light of the 3-bit global configuration.
// R3: In split 16-bit operation half B mode governs half B alone.
// R4: In 32-bit operation half B mode register is ignored; half A governs.
// R5: Bit 14 inverts the half B PWM output when set; resets 0.
// R6: Bit 13 lets the half B trigger out when set; resets 0. The code passes it only in one-shot and periodic mode.
// R7: Bits 11:10 pick capture edge: 0 rise, 1 fall, 3 both.
// R8: Control bits 31:15 and 12 read zero and ignore writes.
// R9: Software keeps reserved bits by read-modify-write.
// R10: Control register refines configuration and carries stall-type enables.
// R11: Global configuration 4 to 7 selects split operation.
// R12: Capture style 0 counts edges, 1 times edges.
// R13: For PWM software sets alternate select, clears style, writes mode 2.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module tbc_top #(
    parameter int CTL_WIDTH = 32
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Timer B datapath side
    input wire logic pwm_raw_i,
    input wire logic trigger_raw_i,
    input wire logic capture_pin_i,
    output logic pwm_o,
    output logic trigger_o,
    output logic capture_event_o,
    output tbc_pkg::tbc_eff_s eff_cfg_o
);

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [11:0] rd_addr;
    logic rd_pend;
    wire logic addr_valid;
    wire logic word_xfer;

    assign word_xfer = (hsize_i == tbc_pkg::HSIZE_WORD);
    assign addr_valid = hsel_i && hready_i && htrans_i[1] && word_xfer;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 12'h000;
            rd_addr <= 12'h000;
        end else if (hready_i) begin
            wr_pend <= addr_valid && hwrite_i;
            rd_pend <= addr_valid && !hwrite_i;
            wr_addr <= haddr_i[11:0];
            rd_addr <= haddr_i[11:0];
        end
    end

    // Zero wait states and always OKAY; unmapped reads return zero.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire logic wr_cfg;
    wire logic wr_mode_a;
    wire logic wr_mode_b;
    wire logic wr_ctl;

    assign wr_cfg = wr_pend && (wr_addr == tbc_pkg::OFS_GLOBAL_CFG);
    assign wr_mode_a = wr_pend && (wr_addr == tbc_pkg::OFS_HALF_A_MODE);
    assign wr_mode_b = wr_pend && (wr_addr == tbc_pkg::OFS_HALF_B_MODE);
    assign wr_ctl = wr_pend && (wr_addr == tbc_pkg::OFS_CONTROL);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0] global_width_config;
    logic [CTL_WIDTH-1:0] timer_control_register;
    tbc_pkg::tbc_mode_s half_a_mode_register;
    tbc_pkg::tbc_mode_s half_b_mode_register;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            global_width_config <= tbc_pkg::RST_CFG;
        end else if (wr_cfg) begin
            global_width_config <= hwdata_i[tbc_pkg::CFG_LSB +: 3];
        end
    end

    // Reserved control bits never take a write, so they read back zero.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_control_register <= tbc_pkg::RST_CONTROL[CTL_WIDTH-1:0];
        end else if (wr_ctl) begin
            timer_control_register <= hwdata_i[CTL_WIDTH-1:0]
                & tbc_pkg::CTL_WRITE_MASK[CTL_WIDTH-1:0]; // R8 R9
        end
    end

    tbc_mode_reg u_mode_a (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_mode_a),
        .wr_data_i(hwdata_i[3:0]),
        .value_o(half_a_mode_register)
    );

    tbc_mode_reg u_mode_b (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_mode_b),
        .wr_data_i(hwdata_i[3:0]),
        .value_o(half_b_mode_register)
    );

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    wire logic half_b_pwm_invert;
    wire logic half_b_trigger_out_enable;
    wire logic [1:0] half_b_edge_select;

    assign half_b_pwm_invert = timer_control_register[tbc_pkg::CTL_INV_BIT];
    assign half_b_trigger_out_enable = timer_control_register[tbc_pkg::CTL_TRIG_BIT];
    assign half_b_edge_select = timer_control_register[tbc_pkg::CTL_EDGE_LSB +: 2];

    // ------------------------------------------------------------------
    // Effective mode selection
    // ------------------------------------------------------------------
    wire logic split_mode;
    tbc_pkg::tbc_mode_s active_mode;
    wire logic [1:0] half_b_mode_field;

    assign split_mode = (global_width_config >= tbc_pkg::CFG_SPLIT_MIN); // R2 R11
    // In 32-bit operation the half B register is ignored entirely.
    assign active_mode = split_mode ? half_b_mode_register // R3
        : half_a_mode_register; // R4
    assign half_b_mode_field = active_mode.mode;

    wire logic mode_capture;
    wire logic mode_counting;
    wire logic pwm_active;

    assign mode_capture = (half_b_mode_field == tbc_pkg::TBC_MODE_CAPTURE); // R1
    assign mode_counting = (half_b_mode_field == tbc_pkg::TBC_MODE_ONESHOT)
        || (half_b_mode_field == tbc_pkg::TBC_MODE_PERIODIC); // R1
    // PWM needs alternate select, edge-count style and periodic mode.
    assign pwm_active = active_mode.alt_select && !active_mode.capture_style
        && (half_b_mode_field == tbc_pkg::TBC_MODE_PERIODIC); // R13

    wire logic rise_en;
    wire logic fall_en;

    assign rise_en = (half_b_edge_select == tbc_pkg::TBC_EDGE_RISE)
        || (half_b_edge_select == tbc_pkg::TBC_EDGE_BOTH); // R7
    assign fall_en = (half_b_edge_select == tbc_pkg::TBC_EDGE_FALL)
        || (half_b_edge_select == tbc_pkg::TBC_EDGE_BOTH); // R7

    // ------------------------------------------------------------------
    // Capture input
    // ------------------------------------------------------------------
    logic cap_level;
    logic cap_rise;
    logic cap_fall;

    tbc_edge_sync u_cap_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(capture_pin_i),
        .level_o(cap_level),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    wire logic cap_hit;

    // Reserved edge code enables neither edge, so no event is reported.
    assign cap_hit = mode_capture && !pwm_active
        && ((cap_rise && rise_en) || (cap_fall && fall_en)); // R7

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    tbc_pkg::tbc_eff_s next_eff;

    always_comb begin
        next_eff.split = split_mode;
        next_eff.mode = half_b_mode_field;
        next_eff.pwm_en = pwm_active;
        next_eff.edge_time = active_mode.capture_style; // R12
        next_eff.edge_sel = half_b_edge_select;
        next_eff.rise_en = rise_en;
        next_eff.fall_en = fall_en;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
            trigger_o <= 1'b0;
            capture_event_o <= 1'b0;
            eff_cfg_o <= '0;
        end else begin
            pwm_o <= pwm_raw_i ^ half_b_pwm_invert; // R5
            trigger_o <= trigger_raw_i && half_b_trigger_out_enable && mode_counting; // R6
            capture_event_o <= cap_hit;
            eff_cfg_o <= next_eff; // R10
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire logic [31:0] rd_cfg;
    wire logic [31:0] rd_ctl;
    wire logic [31:0] rd_mode_a;
    wire logic [31:0] rd_mode_b;
    wire logic [31:0] rd_status;

    assign rd_cfg = {29'h0000_0000, global_width_config};
    assign rd_ctl = {{(32 - CTL_WIDTH){1'b0}}, timer_control_register}; // R8
    assign rd_mode_a = {28'h000_0000, half_a_mode_register};
    assign rd_mode_b = {28'h000_0000, half_b_mode_register};
    assign rd_status = {24'h00_0000, cap_level, pwm_active, mode_capture,
        mode_counting, split_mode, 1'b0, half_b_mode_field};

    always_comb begin
        hrdata_o = 32'h0000_0000;
        if (rd_pend) begin
            case (rd_addr)
                tbc_pkg::OFS_GLOBAL_CFG: hrdata_o = rd_cfg;
                tbc_pkg::OFS_HALF_A_MODE: hrdata_o = rd_mode_a;
                tbc_pkg::OFS_HALF_B_MODE: hrdata_o = rd_mode_b;
                tbc_pkg::OFS_CONTROL: hrdata_o = rd_ctl;
                tbc_pkg::OFS_STATUS: hrdata_o = rd_status;
                default: hrdata_o = 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

/* verif/tbc_props.sv */
// Concurrent checks on the ports of the timer B configuration block.
`timescale 1ns/1ps
`default_nettype none
module tbc_props (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus side
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    // Datapath side
    input wire logic pwm_raw_i,
    input wire logic trigger_raw_i,
    input wire logic pwm_o,
    input wire logic trigger_o,
    input wire logic capture_event_o,
    input wire tbc_pkg::tbc_eff_s eff_cfg_o
);
    // Shadows of the writable fields land on the same edge as the real registers.
    logic wp;
    logic [11:0] wa;
    logic [2:0] cfg;
    logic [1:0] ma;
    logic [1:0] mb;
    logic inv;
    logic ten;
    wire acc = hsel_i && hready_i && htrans_i[1] && hsize_i == tbc_pkg::HSIZE_WORD;
    wire split_x = cfg >= tbc_pkg::CFG_SPLIT_MIN;
    wire [1:0] mode_x = split_x ? mb : ma;
    wire pwm_x = pwm_raw_i ^ inv;
    wire trg_x = trigger_raw_i && ten && (mode_x[0] ^ mode_x[1]);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp <= 1'h0;
            wa <= 12'h0;
            cfg <= 3'h0;
            ma <= 2'h0;
            mb <= 2'h0;
            inv <= 1'h0;
            ten <= 1'h0;
        end else begin
            wp <= acc && hwrite_i;
            wa <= haddr_i[11:0];
            if (wp && wa == tbc_pkg::OFS_GLOBAL_CFG) cfg <= hwdata_i[2:0];
            if (wp && wa == tbc_pkg::OFS_HALF_A_MODE) ma <= hwdata_i[1:0];
            if (wp && wa == tbc_pkg::OFS_HALF_B_MODE) mb <= hwdata_i[1:0];
            if (wp && wa == tbc_pkg::OFS_CONTROL) inv <= hwdata_i[14];
            if (wp && wa == tbc_pkg::OFS_CONTROL) ten <= hwdata_i[13];
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_rd_ctl;
        acc && !hwrite_i && haddr_i[11:0] == tbc_pkg::OFS_CONTROL;
    endsequence
    a_pwm_level: assert property (!$past(rst_i) |-> pwm_o == $past(pwm_x))
        else $error("pwm output does not follow raw level and invert bit");
    a_trig_gate: assert property (!$past(rst_i) |-> trigger_o == $past(trg_x))
        else $error("trigger output gating wrong");
    a_split_cfg: assert property (!$past(rst_i) |-> eff_cfg_o.split == $past(split_x))
        else $error("split flag does not match global width");
    a_mode_src: assert property (!$past(rst_i) |-> eff_cfg_o.mode == $past(mode_x))
        else $error("effective mode taken from wrong half");
    a_rise_code: assert property (eff_cfg_o.rise_en |-> eff_cfg_o.edge_sel inside
        {tbc_pkg::TBC_EDGE_RISE, tbc_pkg::TBC_EDGE_BOTH})
        else $error("rising edge enabled by wrong code");
    a_fall_code: assert property (eff_cfg_o.fall_en |-> eff_cfg_o.edge_sel inside
        {tbc_pkg::TBC_EDGE_FALL, tbc_pkg::TBC_EDGE_BOTH})
        else $error("falling edge enabled by wrong code");
    a_capt_mode: assert property (capture_event_o |->
        eff_cfg_o.mode == tbc_pkg::TBC_MODE_CAPTURE && !eff_cfg_o.pwm_en)
        else $error("capture event outside capture mode");
    a_rsvd_zero: assert property (s_rd_ctl |=> hrdata_o[31:15] == 17'h0 && !hrdata_o[12])
        else $error("reserved control bits read nonzero");
endmodule
bind tbc_top tbc_props u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .pwm_raw_i(pwm_raw_i),
    .trigger_raw_i(trigger_raw_i), .pwm_o(pwm_o), .trigger_o(trigger_o),
    .capture_event_o(capture_event_o), .eff_cfg_o(eff_cfg_o));
`default_nettype wire

/* verif/tbc_tb_top.sv */
// Self-checking bench for the timer B configuration block.
`timescale 1ns/1ps
`default_nettype none
module tbc_tb_top;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic hsel_i = 1'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic pwm_raw_i = 1'h0;
    logic trigger_raw_i = 1'h0;
    logic capture_pin_i = 1'h0;
    logic rd_dp = 1'h0;
    logic [15:0] seed = 16'h000D;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int check_count = 0;
    wire logic [31:0] hrdata_o;
    wire logic hreadyout_o, hresp_o, pwm_o, trigger_o, capture_event_o;
    tbc_pkg::tbc_eff_s eff_cfg_o;
    tbc_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .pwm_raw_i(pwm_raw_i), .trigger_raw_i(trigger_raw_i),
        .capture_pin_i(capture_pin_i), .pwm_o(pwm_o), .trigger_o(trigger_o),
        .capture_event_o(capture_event_o), .eff_cfg_o(eff_cfg_o));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hwait();
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (hreadyout_o !== 1'h1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
    endtask
    // Reads carry the expected word in d; it is queued for the monitor.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel_i <= 1'h1;
        htrans_i <= tbc_pkg::HTRANS_NONSEQ;
        hwrite_i <= wr;
        haddr_i <= {20'h0, a};
        hwait();
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= wr ? d : 32'h0;
        rd_dp <= !wr;
        if (!wr) exp_q.push_back(d);
        hwait();
        rd_dp <= 1'h0;
    endtask
    task automatic look();
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    always @(posedge core_clk_i) begin
        if (rd_dp === 1'h1 && hreadyout_o === 1'h1) begin
            chk("read data", hrdata_o, exp_q.pop_front());
            chk("read resp", 32'(hresp_o), 32'h0);
        end
    end
    initial begin
        int n;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'h0;
        @(posedge core_clk_i);
        bus(0, tbc_pkg::OFS_CONTROL, 32'h0);
        bus(0, tbc_pkg::OFS_HALF_B_MODE, 32'h0);
        bus(1, tbc_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
        bus(0, tbc_pkg::OFS_CONTROL, 32'h0000_6C00);
        bus(0, 12'h020, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            bus(1, tbc_pkg::OFS_CONTROL, {seed, ~seed});
            bus(0, tbc_pkg::OFS_CONTROL, {seed, ~seed} & 32'h0000_6C00);
        end
        $display("test registers done");
        for (int inv = 0; inv < 2; inv++) begin
            bus(1, tbc_pkg::OFS_CONTROL, 32'(inv) << 14);
            repeat (4) begin
                seed = lfsr(seed);
                pwm_raw_i <= seed[0];
                look();
                chk("pwm", 32'(pwm_o), 32'(seed[0] ^ inv[0]));
                @(posedge core_clk_i);
            end
        end
        $display("test pwm level done");
        bus(1, tbc_pkg::OFS_GLOBAL_CFG, 32'h4);
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                bus(1, tbc_pkg::OFS_HALF_B_MODE, 32'(m));
                bus(1, tbc_pkg::OFS_CONTROL, 32'(e) << 13);
                trigger_raw_i <= 1'h1;
                look();
                chk("trigger", 32'(trigger_o), 32'(e == 1 && (m == 1 || m == 2)));
                chk("eff mode", 32'(eff_cfg_o.mode), 32'(m));
                @(posedge core_clk_i);
                trigger_raw_i <= 1'h0;
            end
        end
        $display("test trigger done");
        bus(1, tbc_pkg::OFS_HALF_A_MODE, 32'h2);
        for (int c = 0; c < 8; c++) begin
            bus(1, tbc_pkg::OFS_GLOBAL_CFG, 32'(c));
            look();
            chk("split", 32'(eff_cfg_o.split), 32'(c >= 4));
            chk("eff mode", 32'(eff_cfg_o.mode), (c >= 4) ? 32'h3 : 32'h2);
            @(posedge core_clk_i);
        end
        $display("test width config done");
        for (int s = 0; s < 4; s++) begin
            bus(1, tbc_pkg::OFS_CONTROL, 32'(s) << 10);
            for (int lv = 1; lv >= 0; lv--) begin
                capture_pin_i <= lv[0];
                n = 0;
                repeat (12) begin
                    @(posedge core_clk_i);
                    n += 32'(capture_event_o);
                end
                chk("capture", 32'(n), 32'(s == 3 || s == 1 - lv));
            end
        end
        bus(1, tbc_pkg::OFS_HALF_B_MODE, 32'h7);
        look();
        chk("edge time", 32'(eff_cfg_o.edge_time), 32'h1);
        @(posedge core_clk_i);
        bus(1, tbc_pkg::OFS_HALF_B_MODE, 32'hA);
        look();
        chk("pwm mode", 32'(eff_cfg_o.pwm_en), 32'h1);
        @(posedge core_clk_i);
        // Pin low, PWM, counting, split, periodic mode.
        bus(0, tbc_pkg::OFS_STATUS, 32'h0000_005A);
        $display("test capture done");
        rst_i <= 1'h1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'h0;
        @(posedge core_clk_i);
        bus(0, tbc_pkg::OFS_CONTROL, 32'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
